//--- bench/isolated_supply_sequencer_tb.sv
// self-checking bench of the isolated supply sequencer
`timescale 1ns/100ps
module isolated_supply_sequencer_tb;
  localparam int unsigned DEG = 40;
  localparam int unsigned TOC = 4000;
  typedef struct {logic [5:0] f; logic lat;} row_t;
  logic clk_sys, arst_n, turnOnInput, pgWire;
  logic vinOk, vinAna, vinOver, biasOk, mLow, aLow, mHigh, aHigh, mBand, aBand, hot, mFb, aFb;
  logic [3:0] vinLevel;
  logic sw, burst, auxEn, auxSrc, latched, pgOut, pgOe;
  logic [2:0] duty;
  logic [3:0] oppDuty;
  logic [4:0] ref5;
  int n_mismatch = 0;
  int tests_run = 0;
  int unsigned cyc = 0;
  row_t rows [6] = '{'{6'h01, 1'b0}, '{6'h02, 1'b0}, '{6'h04, 1'b1},
                     '{6'h08, 1'b1}, '{6'h10, 1'b1}, '{6'h20, 1'b1}};

  assign pgWire = (pgOe === 1'b1) ? pgOut : 1'b1;

  supply_host_model u_host (.clk_sys(clk_sys), .pgWire(pgWire), .turnOnInput(turnOnInput));

  isolated_supply_sequencer #(.DEGLITCH_CYC(DEG), .TIMEOUT_CYC(TOC)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .turnOnInput(turnOnInput), .vinAboveLockout(vinOk),
    .vinAboveAnalogLockout(vinAna), .vinOverLockout(vinOver), .vinLevel(vinLevel),
    .mainAboveBiasLockout(biasOk), .mainLowTrip(mLow), .auxLowTrip(aLow), .mainHighTrip(mHigh),
    .auxHighTrip(aHigh), .mainInBand(mBand), .auxInBand(aBand), .overTemp(hot),
    .mainRailFeedbackLow(mFb), .auxRailFeedbackLow(aFb), .supplyOkNIn(pgWire), .switchEnable(sw),
    .primaryRampDuty(duty), .burstDrive(burst), .overpowerBurstDuty(oppDuty), .secondaryRef(ref5),
    .auxRailDriveEnable(auxEn), .auxRailDriveSource(auxSrc), .latchedOff(latched),
    .supplyOkNOut(pgOut), .supplyOkNOe(pgOe));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic setFaults(input logic [5:0] f);
    @(posedge clk_sys);
    vinOk <= !f[0];
    vinOver <= f[1];
    hot <= f[2];
    mHigh <= f[3];
    mLow <= f[4];
    aHigh <= f[5];
  endtask

  task automatic startUp(input bit stepChk);
    logic [4:0] prev;
    int n;
    u_host.setEnable(1'b1);
    repeat (5) @(posedge clk_sys);
    check("switchEnable", 8'h01, {7'h00, sw});
    check("rampDuty", 8'h01, {5'h00, duty});
    biasOk <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check("rampForced", 8'h07, {5'h00, duty});
    if (stepChk) begin
      prev = 5'h09;
      for (int i = 0; i < 7; i++) begin
        n = 0;
        while (ref5 === prev && n < 1400) begin
          @(posedge clk_sys);
          n++;
        end
        check("refStep", {3'h0, prev + ((i == 0) ? 5'h04 : 5'h02)}, {3'h0, ref5});
        if (i > 0) check("stepHold", 8'h01, {7'h00, n > 1270});
        prev = ref5;
      end
    end
    mLow <= 1'b0;
    aFb <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check("auxEnable", 8'h01, {7'h00, auxEn});
    check("auxSource", 8'h01, {7'h00, auxSrc});
    aLow <= 1'b0;
    mBand <= 1'b1;
    aBand <= 1'b1;
    repeat (DEG - 5) @(posedge clk_sys);
    check("earlyGood", 8'h01, {7'h00, pgWire});
    n = 0;
    while (!u_host.powerGood && n < 12000) begin
      @(posedge clk_sys);
      n++;
    end
    check("powerGood", 8'h01, {7'h00, u_host.powerGood});
    if (stepChk) begin
      n = 0;
      repeat (16) begin
        @(posedge clk_sys);
        n += burst;
      end
      check("babyBurst", 8'h0a, 8'(n));
      mFb <= 1'b0;
      aFb <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check("auxSink", 8'h00, {7'h00, auxSrc});
      n = 0;
      repeat (16) begin
        @(posedge clk_sys);
        n += burst;
      end
      check("burstAboveRef", 8'h00, 8'(n));
      mFb <= 1'b1;
    end
  endtask

  initial begin
    arst_n = 1'b0;
    {vinOk, vinAna, vinOver, biasOk, mLow, aLow, mHigh, aHigh} = 8'hcc;
    {mBand, aBand, hot, mFb, aFb} = 5'h02;
    vinLevel = 4'h5;
    repeat (5) @(posedge clk_sys);
    check("rstDuty", 8'h01, {5'h00, duty});
    check("rstRef", 8'h09, {3'h0, ref5});
    check("rstGood", 8'h01, {7'h00, pgWire});
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check("opDuty", 8'h0a, {4'h0, oppDuty});
    check("idleSwitch", 8'h00, {7'h00, sw});
    foreach (rows[i]) begin
      startUp(i == 0);
      setFaults(rows[i].f);
      repeat (6) @(posedge clk_sys);
      check("faultStop", 8'h00, {7'h00, sw});
      check("faultGood", 8'h01, {7'h00, pgWire});
      check("latch", {7'h00, rows[i].lat}, {7'h00, latched});
      setFaults(6'h00);
      repeat (6) @(posedge clk_sys);
      check("recover", {7'h00, !rows[i].lat}, {7'h00, sw});
      if (rows[i].lat) begin
        u_host.clearLatch(1510);
        repeat (6) @(posedge clk_sys);
        check("clearRun", 8'h01, {7'h00, sw});
      end
      u_host.setEnable(1'b0);
      {biasOk, mLow, aLow} <= 3'h3;
      repeat (6) @(posedge clk_sys);
      check("disable", 8'h00, {7'h00, sw});
    end
    u_host.setEnable(1'b1);
    biasOk <= 1'b0;
    repeat (3 * isolated_supply_pkg::STEP_CYC + 10) @(posedge clk_sys);
    check("rampTop", 8'h04, {5'h00, duty});
    repeat (TOC + 10 - 3 * isolated_supply_pkg::STEP_CYC) @(posedge clk_sys);
    check("timeout", 8'h01, {7'h00, latched});
    u_host.clearLatch(100);
    repeat (6) @(posedge clk_sys);
    check("shortLow", 8'h01, {7'h00, latched});
    setFaults(6'h01);
    vinAna <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check("analogClr", 8'h00, {7'h00, latched});
    vinAna <= 1'b1;
    setFaults(6'h00);
    repeat (6) @(posedge clk_sys);
    check("vinRestart", 8'h01, {7'h00, sw});
    end_sim();
  end
endmodule // isolated_supply_sequencer_tb

//--- bench/supply_host_model.sv
// host controller model: drives enable, watches the power-good wire
`timescale 1ns/100ps
module supply_host_model (
  input  wire logic clk_sys,
  input  wire logic pgWire,
  output logic      turnOnInput
);
  logic powerGood;

  assign powerGood = (pgWire === 1'b0);

  initial turnOnInput = 1'b0;

  task automatic setEnable(input logic v);
    @(posedge clk_sys);
    turnOnInput <= v;
  endtask

  // hold enable low for lowCyc cycles, then raise it
  task automatic clearLatch(input int unsigned lowCyc);
    setEnable(1'b0);
    repeat (lowCyc) @(posedge clk_sys);
    turnOnInput <= 1'b1;
  endtask
endmodule // supply_host_model

//--- rtl/isolated_supply_pkg.sv
// constants, state type and helpers of the isolated supply sequencer
package isolated_supply_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 100;

  // soft-start step length, least time, rounded up
  localparam int unsigned STEP_TIME_NS   = 128000;
  localparam int unsigned STEP_CYC       = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // enable low time that arms the latch clear, least time, rounded up
  localparam int unsigned LATCH_CLEAR_NS  = 150000;
  localparam int unsigned LATCH_CLEAR_CYC = (LATCH_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // start-up deglitch and soft-start timeout, longest times, rounded down
  localparam int unsigned DEGLITCH_NS    = 3000000;
  localparam int unsigned DEGLITCH_CYC_DOC = DEGLITCH_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMEOUT_NS     = 28400000;
  localparam int unsigned TIMEOUT_CYC_DOC  = TIMEOUT_NS / CLK_PERIOD_NS;

  // primary ramp duty in eighths of the burst period
  localparam logic [2:0] DUTY_START      = 3'h1;
  localparam logic [2:0] DUTY_END        = 3'h4;
  localparam logic [2:0] DUTY_FORCED     = 3'h7;

  // secondary reference in units of 0.1 V
  localparam logic [4:0] REF_START       = 5'h09;
  localparam logic [4:0] REF_FIRST_STEP  = 5'h04;
  localparam logic [4:0] REF_STEP        = 5'h02;
  localparam logic [2:0] REF_STEPS       = 3'h7;

  // overpower baby-burst duty in sixteenths, reduced by the input level code
  localparam logic [3:0] OPP_DUTY_MAX    = 4'hf;

  typedef enum logic [2:0] {
    ST_DISABLED   = 3'b000,
    ST_SOFT_START = 3'b001,
    ST_NORMAL     = 3'b011,
    ST_AUTO_PROT  = 3'b010,
    ST_LATCHED    = 3'b110
  } supply_state_t;

  function automatic logic isRunning(input supply_state_t s);
    return (s == ST_SOFT_START) || (s == ST_NORMAL);
  endfunction

endpackage

//--- rtl/isolated_supply_sequencer.sv
// sequencing and protection controller of the isolated supply
//
// Summary of operation
// - with input good and enable high, ramp primary burst duty from 12.5% to 50%.
// - once main rail clears bias lockout, secondary feedback rules and ramp duty is forced high.
// - under secondary control, burst follows main feedback compared with the reference.
// - reference climbs 0.9 V to 2.5 V: one 0.4 V step, six 0.2 V steps, 128 us each.
// - after main rail leaves undervoltage, enable aux rail drive, polarity from aux feedback.
// - after both rails clear undervoltage, wait about 3 ms before pulling power-good low.
// - that deglitch applies only before power-good is first given; afterwards trips act at once.
// - main rail short of bias lockout within 28.4 ms of soft-start latches the device off.
// - enable rising starts soft-start; enable falling stops switching.
// - host holds enable low over 150 us then raises it to clear a latch.
// - power-good is open-drain, pulled low only when fault free and both rails in band.
// - input under and overvoltage recover by themselves; all else latches off.
// - latch holds until enable cycles or input drops below analog lockout and recovers.
// - input below lockout falling level stops switching.
// - input below analog lockout level clears every protection latch.
// - on input recovery, soft-start if enable is high, else wait disabled.
// - overpower inserts a baby burst in each main burst, duty falling as input rises.
// - overtemperature shuts the converter down.
// - output undervoltage latches off, cleared by input recycle or enable toggle.
`timescale 1ns/100ps
module isolated_supply_sequencer #(
  parameter int unsigned DEGLITCH_CYC = isolated_supply_pkg::DEGLITCH_CYC_DOC,
  parameter int unsigned TIMEOUT_CYC  = isolated_supply_pkg::TIMEOUT_CYC_DOC
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       turnOnInput,
  input  wire logic       vinAboveLockout,
  input  wire logic       vinAboveAnalogLockout,
  input  wire logic       vinOverLockout,
  input  wire logic [3:0] vinLevel,
  input  wire logic       mainAboveBiasLockout,
  input  wire logic       mainLowTrip,
  input  wire logic       auxLowTrip,
  input  wire logic       mainHighTrip,
  input  wire logic       auxHighTrip,
  input  wire logic       mainInBand,
  input  wire logic       auxInBand,
  input  wire logic       overTemp,
  input  wire logic       mainRailFeedbackLow,
  input  wire logic       auxRailFeedbackLow,
  input  wire logic       supplyOkNIn,
  output logic            switchEnable,
  output logic [2:0]      primaryRampDuty,
  output logic            burstDrive,
  output logic [3:0]      overpowerBurstDuty,
  output logic [4:0]      secondaryRef,
  output logic            auxRailDriveEnable,
  output logic            auxRailDriveSource,
  output logic            latchedOff,
  output logic            supplyOkNOut,
  output logic            supplyOkNOe
);

  localparam int SYNC_W = 19;

  // two-stage synchroniser for every pin
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  logic [SYNC_W-1:0] pinsRaw;

  logic       turnOnS;
  logic       vinLockS;
  logic       vinAnalogS;
  logic       vinOverS;
  logic [3:0] vinLevelS;
  logic [3:0] vinLevelQ;
  logic [3:0] vinLevelHeld;
  logic       mainBiasS;
  logic       mainLowS;
  logic       auxLowS;
  logic       mainHighS;
  logic       auxHighS;
  logic       mainBandS;
  logic       auxBandS;
  logic       overTempS;
  logic       mainFbLowS;
  logic       auxFbLowS;
  logic       pgPinS;

  isolated_supply_pkg::supply_state_t state;
  isolated_supply_pkg::supply_state_t next_state;

  logic        running;
  logic        nextRunning;
  logic        vinOk;
  logic        uvOk;
  logic        secondaryCtrl;
  logic        auxEnabled;
  logic [31:0] timeoutCnt;
  logic        timeoutHit;
  logic [31:0] deglitchCnt;
  logic        deglitchRun;
  logic        deglitchDone;
  logic [31:0] lowCnt;
  logic        clearArmed;
  logic [2:0]  rampPhase;
  logic [3:0]  babyPhase;
  logic        rampBurst;
  logic        mainBurst;
  logic        babyOn;
  logic [3:0]  oppDuty;
  logic        pgGive;

  soft_start_if ss ();

  ramp_sequencer u_ramp (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ss      (ss)
  );

  assign pinsRaw = {turnOnInput, vinAboveLockout, vinAboveAnalogLockout, vinOverLockout, vinLevel,
                    mainAboveBiasLockout, mainLowTrip, auxLowTrip, mainHighTrip, auxHighTrip,
                    mainInBand, auxInBand, overTemp, mainRailFeedbackLow, auxRailFeedbackLow,
                    supplyOkNIn};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      syncA        <= '0;
      syncB        <= '0;
      vinLevelQ    <= 4'h0;
      vinLevelHeld <= 4'h0;
    end else begin
      syncA        <= pinsRaw;
      syncB        <= syncA;
      vinLevelQ    <= vinLevelS;
      vinLevelHeld <= (vinLevelS == vinLevelQ) ? vinLevelS : vinLevelHeld; // level code taken once stable
    end
  end

  assign {turnOnS, vinLockS, vinAnalogS, vinOverS, vinLevelS, mainBiasS, mainLowS, auxLowS,
          mainHighS, auxHighS, mainBandS, auxBandS, overTempS, mainFbLowS, auxFbLowS, pgPinS} = syncB;

  // decoded conditions
  assign running      = isolated_supply_pkg::isRunning(state);
  assign nextRunning  = isolated_supply_pkg::isRunning(next_state);
  assign vinOk        = vinLockS && !vinOverS;
  assign uvOk         = !mainLowS && !auxLowS;
  assign timeoutHit   = !mainBiasS && (timeoutCnt == TIMEOUT_CYC - 1);
  assign deglitchDone = deglitchRun && (deglitchCnt == DEGLITCH_CYC - 1);
  assign clearArmed   = lowCnt >= isolated_supply_pkg::LATCH_CLEAR_CYC + 1;
  assign pgGive       = (next_state == isolated_supply_pkg::ST_NORMAL) && mainBandS && auxBandS;

  // burst generation
  assign rampBurst = {1'b0, rampPhase} < {1'b0, ss.rampDuty};
  assign mainBurst = secondaryCtrl ? mainFbLowS : rampBurst;
  assign oppDuty   = isolated_supply_pkg::OPP_DUTY_MAX - vinLevelHeld;
  assign babyOn    = babyPhase < oppDuty;

  assign ss.run           = running;
  assign ss.secondaryCtrl = secondaryCtrl;

  // next state; input lockout outranks all, overtemperature outranks enable
  always_comb begin
    next_state = state;
    case (state)
      isolated_supply_pkg::ST_DISABLED: begin
        if (!vinOk) begin
          next_state = isolated_supply_pkg::ST_AUTO_PROT;
        end else if (turnOnS) begin
          next_state = isolated_supply_pkg::ST_SOFT_START;
        end
      end
      isolated_supply_pkg::ST_SOFT_START: begin
        if (!vinOk) begin
          next_state = isolated_supply_pkg::ST_AUTO_PROT;
        end else if (overTempS) begin
          next_state = isolated_supply_pkg::ST_LATCHED;
        end else if (!turnOnS) begin
          next_state = isolated_supply_pkg::ST_DISABLED;
        end else if (timeoutHit || mainHighS) begin
          next_state = isolated_supply_pkg::ST_LATCHED;
        end else if (deglitchDone) begin
          // undervoltage and aux high trips are only judged once the deglitch has run out; main high trip acts at once
          next_state = (uvOk && !auxHighS) ? isolated_supply_pkg::ST_NORMAL
                                           : isolated_supply_pkg::ST_LATCHED;
        end
      end
      isolated_supply_pkg::ST_NORMAL: begin
        if (!vinOk) begin
          next_state = isolated_supply_pkg::ST_AUTO_PROT;
        end else if (overTempS) begin
          next_state = isolated_supply_pkg::ST_LATCHED;
        end else if (!turnOnS) begin
          next_state = isolated_supply_pkg::ST_DISABLED;
        end else if (!uvOk || mainHighS || auxHighS) begin
          next_state = isolated_supply_pkg::ST_LATCHED;
        end
      end
      isolated_supply_pkg::ST_AUTO_PROT: begin
        if (vinOk) begin
          next_state = turnOnS ? isolated_supply_pkg::ST_SOFT_START
                               : isolated_supply_pkg::ST_DISABLED;
        end
      end
      isolated_supply_pkg::ST_LATCHED: begin
        if (!vinAnalogS) begin
          next_state = isolated_supply_pkg::ST_AUTO_PROT;
        end else if (clearArmed && turnOnS && vinOk) begin
          next_state = isolated_supply_pkg::ST_SOFT_START;
        end
      end
      default: begin
        next_state = isolated_supply_pkg::ST_DISABLED;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= isolated_supply_pkg::ST_DISABLED;
    end else begin
      state <= next_state;
    end
  end

  // hand-over to secondary feedback and aux rail enable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      secondaryCtrl <= 1'b0;
      auxEnabled    <= 1'b0;
    end else if (!running) begin
      secondaryCtrl <= 1'b0;
      auxEnabled    <= 1'b0;
    end else begin
      secondaryCtrl <= secondaryCtrl || mainBiasS;
      auxEnabled    <= auxEnabled || !mainLowS;
    end
  end

  // soft-start timeout, counts until the hand-over
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timeoutCnt <= 32'h0000_0000;
    end else if (state != isolated_supply_pkg::ST_SOFT_START || secondaryCtrl) begin
      timeoutCnt <= 32'h0000_0000;
    end else if (!timeoutHit) begin
      timeoutCnt <= timeoutCnt + 32'h0000_0001;
    end
  end

  // start-up deglitch, begins once both rails have cleared undervoltage
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      deglitchRun <= 1'b0;
      deglitchCnt <= 32'h0000_0000;
    end else if (state != isolated_supply_pkg::ST_SOFT_START) begin
      deglitchRun <= 1'b0;
      deglitchCnt <= 32'h0000_0000;
    end else if (!deglitchRun) begin
      deglitchRun <= uvOk && auxEnabled;
    end else if (!deglitchDone) begin
      deglitchCnt <= deglitchCnt + 32'h0000_0001;
    end
  end

  // enable low time while latched
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt <= 32'h0000_0000;
    end else if (state != isolated_supply_pkg::ST_LATCHED) begin
      lowCnt <= 32'h0000_0000;
    end else if (!turnOnS && !clearArmed) begin
      lowCnt <= lowCnt + 32'h0000_0001;
    end else if (turnOnS && !clearArmed) begin
      lowCnt <= 32'h0000_0000;
    end
  end

  // burst phase counters
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rampPhase <= 3'h0;
      babyPhase <= 4'h0;
    end else begin
      rampPhase <= rampPhase + 3'h1;
      babyPhase <= babyPhase + 4'h1;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      switchEnable       <= 1'b0;
      primaryRampDuty    <= isolated_supply_pkg::DUTY_START;
      burstDrive         <= 1'b0;
      overpowerBurstDuty <= isolated_supply_pkg::OPP_DUTY_MAX;
      secondaryRef       <= isolated_supply_pkg::REF_START;
      auxRailDriveEnable <= 1'b0;
      auxRailDriveSource <= 1'b0;
      latchedOff         <= 1'b0;
      supplyOkNOe        <= 1'b0;
    end else begin
      switchEnable       <= nextRunning;
      primaryRampDuty    <= secondaryCtrl ? isolated_supply_pkg::DUTY_FORCED : ss.rampDuty;
      burstDrive         <= nextRunning && mainBurst && babyOn;
      overpowerBurstDuty <= oppDuty;
      secondaryRef       <= ss.refCode;
      auxRailDriveEnable <= nextRunning && auxEnabled;
      auxRailDriveSource <= auxFbLowS;
      latchedOff         <= next_state == isolated_supply_pkg::ST_LATCHED;
      supplyOkNOe        <= pgGive;
    end
  end

  // open drain: only ever pulls low
  assign supplyOkNOut = 1'b0;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence latchedIdle;
    state == isolated_supply_pkg::ST_LATCHED && vinAnalogS;
  endsequence

  sequence normalEntry;
    $rose(state == isolated_supply_pkg::ST_NORMAL);
  endsequence

  pg_normal_only_a: assert property (supplyOkNOe |-> state == isolated_supply_pkg::ST_NORMAL)
    else $error("power-good given outside normal running");

  pg_in_band_a: assert property (supplyOkNOe |-> $past(mainBandS) && $past(auxBandS))
    else $error("power-good given with a rail out of band");

  lockout_stop_a: assert property (!vinLockS |=> !switchEnable)
    else $error("switching continued in input lockout");

  enable_stop_a: assert property (running && !turnOnS |=> !switchEnable)
    else $error("switching continued with enable low");

  timeout_latch_a: assert property ((state == isolated_supply_pkg::ST_SOFT_START && vinOk && turnOnS
                                     && timeoutHit) |=> state == isolated_supply_pkg::ST_LATCHED)
    else $error("soft-start timeout did not latch off");

  ramp_forced_a: assert property ($rose(secondaryCtrl)
    |=> primaryRampDuty == isolated_supply_pkg::DUTY_FORCED)
    else $error("ramp duty not forced at hand-over");

  latch_holds_a: assert property ((latchedIdle and !(clearArmed && turnOnS)) |=> latchedOff)
    else $error("latch left without enable cycle or input recycle");

  analog_clear_a: assert property ((state == isolated_supply_pkg::ST_LATCHED && !vinAnalogS)
                                   |=> state == isolated_supply_pkg::ST_AUTO_PROT)
    else $error("analog lockout did not clear the latch");

  uv_latch_a: assert property ((state == isolated_supply_pkg::ST_NORMAL && vinOk && !overTempS && turnOnS
                                && !uvOk) |=> state == isolated_supply_pkg::ST_LATCHED)
    else $error("output undervoltage did not latch off");

  deglitch_first_a: assert property (normalEntry |-> $past(deglitchDone))
    else $error("normal running entered before the deglitch ran out");

  secondary_burst_a: assert property ((secondaryCtrl && !mainFbLowS) |=> !burstDrive)
    else $error("burst driven above the reference");

  overtemp_stop_a: assert property ((running && vinOk && overTempS) |=> latchedOff ##0 !switchEnable)
    else $error("overtemperature did not shut down");

  pg_readback_a: assert property ((supplyOkNOe && $past(supplyOkNOe) && $past(supplyOkNOe, 2)) |-> !pgPinS)
    else $error("power-good wire not pulled low");

endmodule // isolated_supply_sequencer

//--- rtl/ramp_sequencer.sv
// primary duty ramp and stepped secondary reference for soft-start
`timescale 1ns/100ps
module ramp_sequencer (
  input  wire logic  clk_sys,
  input  wire logic  arst_n,
  soft_start_if.seq  ss
);

  logic [15:0] stepCnt;
  logic [2:0]  refSteps;
  logic        secCtrlQ;
  logic        secStart;
  logic        rampMore;
  logic        refMore;

  assign secStart    = ss.secondaryCtrl && !secCtrlQ;
  assign ss.stepTick = ss.run && !secStart && (stepCnt == 16'(isolated_supply_pkg::STEP_CYC - 1));
  assign rampMore    = ss.rampDuty < isolated_supply_pkg::DUTY_END;
  assign refMore     = refSteps < isolated_supply_pkg::REF_STEPS;
  assign ss.refDone  = !refMore;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stepCnt     <= 16'h0000;
      secCtrlQ    <= 1'b0;
      ss.rampDuty <= isolated_supply_pkg::DUTY_START;
      ss.refCode  <= isolated_supply_pkg::REF_START;
      refSteps    <= 3'h0;
    end else if (!ss.run) begin
      stepCnt     <= 16'h0000;
      secCtrlQ    <= 1'b0;
      ss.rampDuty <= isolated_supply_pkg::DUTY_START;
      ss.refCode  <= isolated_supply_pkg::REF_START;
      refSteps    <= 3'h0;
    end else begin
      secCtrlQ <= ss.secondaryCtrl;
      // the first reference step gets a full period after hand-over
      if (ss.stepTick || secStart) begin
        stepCnt <= 16'h0000;
      end else begin
        stepCnt <= stepCnt + 16'h0001;
      end
      if (ss.stepTick && !ss.secondaryCtrl && rampMore) begin
        ss.rampDuty <= ss.rampDuty + 3'h1;
      end
      if (ss.stepTick && ss.secondaryCtrl && refMore) begin
        ss.refCode <= ss.refCode + ((refSteps == 3'h0) ? isolated_supply_pkg::REF_FIRST_STEP
                                                     : isolated_supply_pkg::REF_STEP);
        refSteps   <= refSteps + 3'h1;
      end
    end
  end

  ref_step_held_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ss.run && $past(ss.run) && $changed(ss.refCode)) |-> $past(ss.stepTick))
    else $error("reference moved without a step tick");

  ref_ceiling_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ss.refDone |-> (ss.refCode == 5'h19))
    else $error("reference did not end at 2.5 V");

endmodule // ramp_sequencer

//--- rtl/soft_start_if.sv
// signals between the supply controller and its soft-start ramp sequencer
`timescale 1ns/100ps
interface soft_start_if;
  logic       run;
  logic       secondaryCtrl;
  logic [2:0] rampDuty;
  logic [4:0] refCode;
  logic       refDone;
  logic       stepTick;

  modport seq (input run, input secondaryCtrl, output rampDuty, output refCode, output refDone, output stepTick);
  modport ctl (output run, output secondaryCtrl, input rampDuty, input refCode, input refDone, input stepTick);
endinterface
